// File: rtl/uart_trig_defines.svh
// Register map, field positions and reset values of the UART trigger decoder
`ifndef UART_TRIG_DEFINES_SVH
`define UART_TRIG_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UT_REG_CTRL    8'h00
`define UT_REG_BAUD    8'h04
`define UT_REG_TOUT    8'h08
`define UT_REG_TRIG    8'h0C
`define UT_REG_PAT     8'h10
`define UT_REG_STAT    8'h14
`define UT_REG_WINFO   8'h18
`define UT_REG_WSTART  8'h1C
`define UT_REG_WSTOP   8'h20
`define UT_REG_RATE    8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UT_CTRL_EN     0
`define UT_CTRL_PAR    2:1
`define UT_CTRL_MSB    3
`define UT_CTRL_IDLELO 4
`define UT_CTRL_PKTEN  5
`define UT_CTRL_DBITS  11:8
`define UT_CTRL_SBITS  13:12
`define UT_TRIG_TYPE   2:0
`define UT_TRIG_SRC    3
`define UT_TRIG_OP     5:4
`define UT_TRIG_NWORDS 9:8
`define UT_TRIG_POS    23:16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UT_CTRL_RST    32'h0000_1800
`define UT_BAUD_RST    16'h0364
`define UT_TOUT_RST    24'h00_2710
`define UT_TRIG_RST    32'h0000_0000
`define UT_PAT_RST     32'h0000_0000

`endif

// File: rtl/uart_trig_pkg.sv
// Types shared by the UART trigger decoder
package uart_trig_pkg;

  typedef enum logic [5:0] {
    LS_IDLE  = 6'h01,
    LS_START = 6'h02,
    LS_DATA  = 6'h04,
    LS_PAR   = 6'h08,
    LS_STOP  = 6'h10,
    LS_HOLD  = 6'h20
  } line_state_t;

  typedef enum logic [2:0] {
    WS_OK      = 3'h0,
    WS_STARTER = 3'h1,
    WS_STOPER  = 3'h2,
    WS_PARER   = 3'h3,
    WS_INSUF   = 3'h4
  } word_status_t;

  typedef enum logic [2:0] {
    TT_START  = 3'h0,
    TT_PACKET = 3'h1,
    TT_DATA   = 3'h2,
    TT_PARITY = 3'h3,
    TT_BREAK  = 3'h4,
    TT_STOP   = 3'h5
  } trig_type_t;

  typedef enum logic [1:0] {
    OP_EQ = 2'h0,
    OP_NE = 2'h1,
    OP_LT = 2'h2,
    OP_GE = 2'h3
  } cmp_op_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ODD  = 2'h1,
    PAR_EVEN = 2'h2
  } parity_t;

endpackage

// File: rtl/uart_protocol_trigger_decoder.sv
// UART line decoder with event trigger and per-word result record
`include "uart_trig_defines.svh"

module uart_protocol_trigger_decoder #(
  parameter int DATA_W    = 8,
  parameter int PAT_WORDS = 4
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Observed lines
  input  wire logic        txLine,
  input  wire logic        rxLine,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Trigger
  output logic             trigger
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [15:0] baud;
  logic [23:0] tout;
  logic [31:0] trig;
  logic [31:0] pattern;
  logic [5:0]  flags;

  wire wrStat = ce && regWr && regAddr == `UT_REG_STAT;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl    <= `UT_CTRL_RST;
      baud    <= `UT_BAUD_RST;
      tout    <= `UT_TOUT_RST;
      trig    <= `UT_TRIG_RST;
      pattern <= `UT_PAT_RST;
    end else if (ce && regWr) begin
      case (regAddr)
        `UT_REG_CTRL: ctrl    <= regWdata;
        `UT_REG_BAUD: baud    <= regWdata[15:0];
        `UT_REG_TOUT: tout    <= regWdata[23:0];
        `UT_REG_TRIG: trig    <= regWdata;
        `UT_REG_PAT:  pattern <= regWdata;
        default: ;
      endcase
    end
  end

  wire                    en      = ctrl[`UT_CTRL_EN];
  wire                    msbSel  = ctrl[`UT_CTRL_MSB];
  wire                    idleLow = ctrl[`UT_CTRL_IDLELO];
  wire                    pktEn   = ctrl[`UT_CTRL_PKTEN];
  wire [1:0]              sBits   = ctrl[`UT_CTRL_SBITS];
  wire                    src     = trig[`UT_TRIG_SRC];
  wire [1:0]              lastIdx = trig[`UT_TRIG_NWORDS];
  wire [7:0]              position = trig[`UT_TRIG_POS];
  uart_trig_pkg::parity_t    parMode;
  uart_trig_pkg::trig_type_t trigType;
  uart_trig_pkg::cmp_op_t    cmpOp;
  logic [3:0]             dBits;

  assign parMode  = uart_trig_pkg::parity_t'(ctrl[`UT_CTRL_PAR]);
  assign trigType = uart_trig_pkg::trig_type_t'(trig[`UT_TRIG_TYPE]);
  assign cmpOp    = uart_trig_pkg::cmp_op_t'(trig[`UT_TRIG_OP]);

  // Word length clamped to 5..DATA_W
  always_comb begin
    dBits = ctrl[`UT_CTRL_DBITS];
    if (dBits < 4'h5)
      dBits = 4'h5;
    else if (dBits > 4'(DATA_W))
      dBits = 4'(DATA_W);
  end

  // ----------------------------------------
  // Timestamp
  // ----------------------------------------
  logic [31:0] now;

  always_ff @(posedge clk) begin
    if (rst)
      now <= 32'h0000_0000;
    else if (ce)
      now <= now + 32'h0000_0001;
  end

  // ----------------------------------------
  // Line decoders, index 0 transmit, 1 receive
  // ----------------------------------------
  wire [1:0]                   pins = {rxLine, txLine};
  logic [2:0]                  syncQ   [2];
  logic                        lvl     [2];
  logic                        mark    [2];
  uart_trig_pkg::line_state_t  st      [2];
  logic [15:0]                 cnt     [2];
  logic [3:0]                  idx     [2];
  logic [DATA_W-1:0]           sh      [2];
  logic                        par     [2];
  logic                        parBad  [2];
  logic [1:0]                  stopLeft [2];
  logic                        pktOpen [2];
  logic [23:0]                 idle    [2];
  logic [7:0]                  pos     [2];
  logic                        startEv [2];
  logic                        pktEv   [2];
  logic                        doneEv  [2];
  logic                        brkEv   [2];
  logic [31:0]                 tStart  [2];
  logic [31:0]                 tStop   [2];
  logic [DATA_W-1:0]           wVal    [2];
  uart_trig_pkg::word_status_t wStat   [2];

  for (genvar g = 0; g < 2; g++) begin : g_line
    // Level accepted once the second and third stage agree
    always_ff @(posedge clk) begin
      if (rst) begin
        syncQ[g] <= 3'h7;
        lvl[g]   <= 1'b1;
      end else if (ce) begin
        syncQ[g] <= {syncQ[g][1:0], pins[g]};
        if (syncQ[g][1] == syncQ[g][2])
          lvl[g] <= syncQ[g][2];
      end
    end

    assign mark[g] = lvl[g] ^ idleLow;

    always_ff @(posedge clk) begin
      if (rst) begin
        st[g]       <= uart_trig_pkg::LS_IDLE;
        cnt[g]      <= 16'h0000;
        idx[g]      <= 4'h0;
        sh[g]       <= '0;
        par[g]      <= 1'b0;
        parBad[g]   <= 1'b0;
        stopLeft[g] <= 2'h0;
        pktOpen[g]  <= 1'b0;
        idle[g]     <= 24'h00_0000;
        pos[g]      <= 8'h00;
        startEv[g]  <= 1'b0;
        pktEv[g]    <= 1'b0;
        doneEv[g]   <= 1'b0;
        brkEv[g]    <= 1'b0;
        tStart[g]   <= 32'h0000_0000;
        tStop[g]    <= 32'h0000_0000;
        wVal[g]     <= '0;
        wStat[g]    <= uart_trig_pkg::WS_OK;
      end else if (ce) begin
        startEv[g] <= 1'b0;
        pktEv[g]   <= 1'b0;
        doneEv[g]  <= 1'b0;
        brkEv[g]   <= 1'b0;
        if (!en) begin
          // Word cut short by the end of capture
          if (st[g] != uart_trig_pkg::LS_IDLE && st[g] != uart_trig_pkg::LS_HOLD) begin
            doneEv[g] <= 1'b1;
            wStat[g]  <= uart_trig_pkg::WS_INSUF;
            wVal[g]   <= sh[g];
            tStop[g]  <= now;
          end
          st[g]      <= uart_trig_pkg::LS_IDLE;
          pktOpen[g] <= 1'b0;
          idle[g]    <= 24'h00_0000;
        end else begin
          case (st[g])
            uart_trig_pkg::LS_IDLE: begin
              if (!mark[g]) begin
                st[g]      <= uart_trig_pkg::LS_START;
                cnt[g]     <= baud >> 1;
                tStart[g]  <= now;
                startEv[g] <= 1'b1;
                idle[g]    <= 24'h00_0000;
                sh[g]      <= '0;
                par[g]     <= 1'b0;
                parBad[g]  <= 1'b0;
                idx[g]     <= 4'h0;
                if (!pktOpen[g]) begin
                  pktEv[g]   <= 1'b1;
                  pktOpen[g] <= 1'b1;
                  pos[g]     <= 8'h00;
                end
              end else if (pktOpen[g]) begin
                if (idle[g] >= tout)
                  pktOpen[g] <= 1'b0;
                else
                  idle[g] <= idle[g] + 24'h00_0001;
              end
            end
            uart_trig_pkg::LS_START: begin
              if (cnt[g] != 16'h0000) begin
                cnt[g] <= cnt[g] - 16'h0001;
              end else if (mark[g]) begin
                wStat[g]  <= uart_trig_pkg::WS_STARTER;
                wVal[g]   <= '0;
                tStop[g]  <= now;
                doneEv[g] <= 1'b1;
                st[g]     <= uart_trig_pkg::LS_IDLE;
              end else begin
                st[g]  <= uart_trig_pkg::LS_DATA;
                cnt[g] <= baud - 16'h0001;
              end
            end
            uart_trig_pkg::LS_DATA: begin
              if (cnt[g] != 16'h0000) begin
                cnt[g] <= cnt[g] - 16'h0001;
              end else begin
                if (msbSel)
                  sh[g] <= {sh[g][DATA_W-2:0], mark[g]};
                else
                  sh[g] <= {mark[g], sh[g][DATA_W-1:1]};
                par[g]      <= par[g] ^ mark[g];
                cnt[g]      <= baud - 16'h0001;
                idx[g]      <= idx[g] + 4'h1;
                stopLeft[g] <= (sBits == 2'h0) ? 2'h1 : sBits;
                if (idx[g] == dBits - 4'h1)
                  st[g] <= (parMode == uart_trig_pkg::PAR_NONE) ?
                           uart_trig_pkg::LS_STOP : uart_trig_pkg::LS_PAR;
              end
            end
            uart_trig_pkg::LS_PAR: begin
              if (cnt[g] != 16'h0000) begin
                cnt[g] <= cnt[g] - 16'h0001;
              end else begin
                parBad[g] <= (par[g] ^ mark[g]) != (parMode == uart_trig_pkg::PAR_ODD);
                cnt[g]    <= baud - 16'h0001;
                st[g]     <= uart_trig_pkg::LS_STOP;
              end
            end
            uart_trig_pkg::LS_STOP: begin
              if (cnt[g] != 16'h0000) begin
                cnt[g] <= cnt[g] - 16'h0001;
              end else if (mark[g] && stopLeft[g] > 2'h1) begin
                stopLeft[g] <= stopLeft[g] - 2'h1;
                cnt[g]      <= baud - 16'h0001;
              end else begin
                doneEv[g] <= 1'b1;
                tStop[g]  <= now;
                wVal[g]   <= msbSel ? sh[g] : sh[g] >> (4'(DATA_W) - dBits);
                if (pos[g] != 8'hFF)
                  pos[g] <= pos[g] + 8'h01;
                if (!mark[g]) begin
                  wStat[g] <= uart_trig_pkg::WS_STOPER;
                  brkEv[g] <= sh[g] == '0;
                  st[g]    <= uart_trig_pkg::LS_HOLD;
                end else begin
                  wStat[g] <= parBad[g] ? uart_trig_pkg::WS_PARER :
                              uart_trig_pkg::WS_OK;
                  st[g]    <= uart_trig_pkg::LS_IDLE;
                end
              end
            end
            uart_trig_pkg::LS_HOLD: begin
              // Next start only after the line returns to idle
              if (mark[g])
                st[g] <= uart_trig_pkg::LS_IDLE;
            end
            default: st[g] <= uart_trig_pkg::LS_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Data pattern match
  // ----------------------------------------
  logic [1:0]        matchIdx;
  logic              dead;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] patWord;
  logic [DATA_W-1:0] gotWord;
  logic              cmpOk;
  logic              inWindow;

  assign mask     = {DATA_W{1'b1}} >> (4'(DATA_W) - dBits);
  assign patWord  = pattern[matchIdx * DATA_W +: DATA_W] & mask;
  assign gotWord  = wVal[src] & mask;
  assign inWindow = !pktEn || pos[src] > position;

  always_comb begin
    case (cmpOp)
      uart_trig_pkg::OP_EQ: cmpOk = gotWord == patWord;
      uart_trig_pkg::OP_NE: cmpOk = gotWord != patWord;
      uart_trig_pkg::OP_LT: cmpOk = gotWord < patWord;
      uart_trig_pkg::OP_GE: cmpOk = gotWord >= patWord;
      default:              cmpOk = 1'b0;
    endcase
  end

  wire wordCheck = doneEv[src] && wStat[src] == uart_trig_pkg::WS_OK && inWindow && !dead;
  wire dataHit   = wordCheck && cmpOk && matchIdx == lastIdx;

  always_ff @(posedge clk) begin
    if (rst) begin
      matchIdx <= 2'h0;
      dead     <= 1'b0;
    end else if (ce) begin
      if (pktEv[src]) begin
        matchIdx <= 2'h0;
        dead     <= 1'b0;
      end else if (wordCheck) begin
        // One compare window per packet when packets are detected
        if (cmpOk && matchIdx != lastIdx) begin
          matchIdx <= matchIdx + 2'h1;
        end else begin
          matchIdx <= 2'h0;
          dead     <= pktEn;
        end
      end
    end
  end

  // ----------------------------------------
  // Trigger selection
  // ----------------------------------------
  logic fire;

  always_comb begin
    case (trigType)
      uart_trig_pkg::TT_START:  fire = startEv[src];
      uart_trig_pkg::TT_PACKET: fire = pktEv[src];
      uart_trig_pkg::TT_DATA:   fire = dataHit;
      uart_trig_pkg::TT_PARITY: fire = doneEv[src] && parMode != uart_trig_pkg::PAR_NONE &&
                                       wStat[src] == uart_trig_pkg::WS_PARER;
      uart_trig_pkg::TT_BREAK:  fire = brkEv[src];
      uart_trig_pkg::TT_STOP:   fire = doneEv[src] && wStat[src] == uart_trig_pkg::WS_STOPER;
      default:                  fire = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst)
      trigger <= 1'b0;
    else if (ce)
      trigger <= en && fire;
  end

  // ----------------------------------------
  // Word record and sticky flags
  // ----------------------------------------
  logic [15:0]       recIdx;
  logic [DATA_W-1:0] recVal;
  logic [2:0]        recStat;
  logic              recSrc;
  logic [31:0]       recStart;
  logic [31:0]       recStop;
  logic [5:0]        setF;

  always_ff @(posedge clk) begin
    if (rst) begin
      recIdx   <= 16'h0000;
      recVal   <= '0;
      recStat  <= 3'h0;
      recSrc   <= 1'b0;
      recStart <= 32'h0000_0000;
      recStop  <= 32'h0000_0000;
    end else if (ce && doneEv[src]) begin
      recIdx   <= recIdx + 16'h0001;
      recVal   <= wVal[src];
      recStat  <= wStat[src];
      recSrc   <= src;
      recStart <= tStart[src];
      recStop  <= tStop[src];
    end
  end

  always_comb begin
    setF    = 6'h00;
    setF[0] = doneEv[src] && wStat[src] == uart_trig_pkg::WS_STARTER;
    setF[1] = doneEv[src] && wStat[src] == uart_trig_pkg::WS_STOPER;
    setF[2] = doneEv[src] && wStat[src] == uart_trig_pkg::WS_PARER;
    setF[3] = brkEv[src];
    setF[4] = doneEv[src] && wStat[src] == uart_trig_pkg::WS_INSUF;
    setF[5] = trigger;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst)
      flags <= 6'h00;
    else if (ce)
      flags <= (flags & ~(wrStat ? regWdata[5:0] : 6'h00)) | setF;
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else if (ce) begin
      regRdata <= 32'h0000_0000;
      if (regRd) begin
        case (regAddr)
          `UT_REG_CTRL:   regRdata <= ctrl;
          `UT_REG_BAUD:   regRdata <= {16'h0000, baud};
          `UT_REG_TOUT:   regRdata <= {8'h00, tout};
          `UT_REG_TRIG:   regRdata <= trig;
          `UT_REG_PAT:    regRdata <= pattern;
          `UT_REG_STAT:   regRdata <= {24'h00_0000, st[src] == uart_trig_pkg::LS_IDLE, pktOpen[src], flags};
          `UT_REG_WINFO:  regRdata <= {recIdx, 3'h0, recSrc, 1'b0, recStat, 8'(recVal)};
          `UT_REG_WSTART: regRdata <= recStart;
          `UT_REG_WSTOP:  regRdata <= recStop;
          `UT_REG_RATE:   regRdata <= {16'h0000, baud};
          default:        regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  start_trig_a: assert property (@(posedge clk) disable iff (rst)
    ce && en && trigType == uart_trig_pkg::TT_START && startEv[src] |=> trigger)
    else $error("start bit did not trigger");
  pkt_trig_a: assert property (@(posedge clk) disable iff (rst)
    ce && en && trigType == uart_trig_pkg::TT_PACKET && pktEv[src] |=> trigger)
    else $error("packet start did not trigger");
  parity_gate_a: assert property (@(posedge clk) disable iff (rst)
    trigger && $past(trigType) == uart_trig_pkg::TT_PARITY |->
      $past(parMode) != uart_trig_pkg::PAR_NONE)
    else $error("parity trigger without parity");
  stop_flag_a: assert property (@(posedge clk) disable iff (rst)
    ce && doneEv[src] && wStat[src] == uart_trig_pkg::WS_STOPER |=> flags[1])
    else $error("stop error not flagged");
  brk_hold_a: assert property (@(posedge clk) disable iff (rst)
    brkEv[0] |-> st[0] == uart_trig_pkg::LS_HOLD && wStat[0] == uart_trig_pkg::WS_STOPER)
    else $error("break without held line");
  rec_index_a: assert property (@(posedge clk) disable iff (rst)
    ce && doneEv[src] |=> recIdx == $past(recIdx) + 16'h0001)
    else $error("record index not advanced");
  centre_wait_a: assert property (@(posedge clk) disable iff (rst)
    ce && en && st[0] == uart_trig_pkg::LS_IDLE && !mark[0] |=>
      st[0] == uart_trig_pkg::LS_START && cnt[0] == $past(baud) >> 1)
    else $error("start sample point wrong");
  sync_agree_a: assert property (@(posedge clk) disable iff (rst)
    $changed(lvl[1]) |-> $past(syncQ[1][1]) == $past(syncQ[1][2]))
    else $error("line level taken before agreement");
  insuf_mark_a: assert property (@(posedge clk) disable iff (rst)
    ce && !en && st[0] == uart_trig_pkg::LS_DATA |=>
      doneEv[0] && wStat[0] == uart_trig_pkg::WS_INSUF)
    else $error("cut word not marked");

endmodule

// File: verification/uart_line_model.sv
// Behavioural sender for the observed transmit and receive lines
module uart_line_model (
  // Clock
  input  wire logic clk,
  // Observed lines
  output logic      txLine,
  output logic      rxLine
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    txLine = 1'b1;
    rxLine = 1'b1;
  end

  // ----------------------------------------
  // Frame sender, idle high, data LSB first
  // ----------------------------------------
  // Parity code 0 none, 1 odd, 2 even, 3 even but corrupted
  task automatic send(input logic src, input logic [7:0] val, input int par,
                      input logic stopLvl, input int baud);
    logic [10:0] bits;
    int          n;
    bits = {2'b11, val, 1'b0};
    n = (par != 0) ? 11 : 10;
    if (par != 0) begin
      bits[9] = ^val ^ (par != 2);
    end
    bits[n - 1] = stopLvl;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (src) rxLine <= bits[i]; else txLine <= bits[i];
      repeat (baud - 1) @(posedge clk);
    end
    @(posedge clk);
    if (src) rxLine <= 1'b1; else txLine <= 1'b1;
    repeat (3 * baud) @(posedge clk);
  endtask
endmodule

// File: verification/test_uart_protocol_trigger_decoder.sv
// Self-checking bench of the UART trigger decoder
module test_uart_protocol_trigger_decoder;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BAUD = 8;

  logic        clk;
  logic        rst;
  logic        ce;
  logic        txLine;
  logic        rxLine;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        trigger;
  logic [31:0] d;
  int          err_count = 0;
  int          comparisons = 0;
  int          trigSeen = 0;
  int          base;

  uart_protocol_trigger_decoder u_dut (
    .clk(clk), .rst(rst), .ce(ce), .txLine(txLine), .rxLine(rxLine),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .trigger(trigger));

  uart_line_model u_far (.clk(clk), .txLine(txLine), .rxLine(rxLine));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (trigger === 1'b1) trigSeen <= trigSeen + 1;

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic frame(input logic s, input logic [7:0] v, input int p, input logic sl);
    base = trigSeen;
    u_far.send(s, v, p, sl, BAUD);
  endtask

  task automatic chkTrig(input int e);
    chk("trigger count", e, trigSeen - base);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(8'h00); chk("ctrl reset", 32'h0000_1800, d);
    rd(8'h04); chk("baud reset", 32'h0000_0364, d);
    rd(8'h08); chk("tout reset", 32'h0000_2710, d);
    rd(8'h30); chk("unmapped read", 32'h0, d);
    $display("test reset done");
  endtask

  task automatic t_start();
    wr(8'h04, BAUD);
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0000_1801);
    frame(1'b0, 8'hA5, 0, 1'b1); chkTrig(1);
    rd(8'h18); chk("word value", 32'hA5, d[7:0]);
    chk("word status", 32'h0, d[10:8]);
    rd(8'h24); chk("rate", BAUD, d);
    frame(1'b1, 8'h33, 0, 1'b1); chkTrig(0);
    wr(8'h00, 32'h0000_1809);
    frame(1'b0, 8'h01, 0, 1'b1);
    rd(8'h18); chk("msb first value", 32'h80, d[7:0]);
    $display("test start done");
  endtask

  task automatic t_parity();
    wr(8'h00, 32'h0000_1805);
    wr(8'h0C, 32'h3);
    wr(8'h14, 32'h3F);
    frame(1'b0, 8'h3C, 2, 1'b1); chkTrig(0);
    frame(1'b0, 8'h3C, 3, 1'b1); chkTrig(1);
    rd(8'h18); chk("parity status", 32'h3, d[10:8]);
    rd(8'h14); chk("parity flag", 32'h1, d[2]);
    $display("test parity done");
  endtask

  task automatic t_stop();
    wr(8'h00, 32'h0000_1801);
    wr(8'h0C, 32'h5);
    wr(8'h14, 32'h3F);
    frame(1'b0, 8'h81, 0, 1'b0); chkTrig(1);
    rd(8'h18); chk("stop status", 32'h2, d[10:8]);
    rd(8'h14); chk("stop flag", 32'h1, d[1]);
    wr(8'h0C, 32'h4);
    frame(1'b0, 8'h00, 0, 1'b0); chkTrig(1);
    rd(8'h14); chk("break flag", 32'h1, d[3]);
    $display("test stop done");
  endtask

  task automatic t_data();
    wr(8'h0C, 32'h0000_000A);
    wr(8'h10, 32'h72);
    frame(1'b1, 8'h11, 0, 1'b1); chkTrig(0);
    frame(1'b1, 8'h72, 0, 1'b1); chkTrig(1);
    wr(8'h0C, 32'h0000_001A);
    frame(1'b1, 8'h72, 0, 1'b1); chkTrig(0);
    wr(8'h0C, 32'h0000_010A);
    wr(8'h10, 32'h3472);
    frame(1'b1, 8'h72, 0, 1'b1); chkTrig(0);
    frame(1'b1, 8'h34, 0, 1'b1); chkTrig(1);
    $display("test data done");
  endtask

  task automatic t_packet();
    wr(8'h00, 32'h0000_1701);
    wr(8'h0C, 32'h0);
    frame(1'b0, 8'h95, 0, 1'b1);
    rd(8'h18); chk("seven bit value", 32'h15, d[7:0]);
    wr(8'h00, 32'h0000_1821);
    wr(8'h08, 32'h20);
    wr(8'h0C, 32'h1);
    repeat (40) @(posedge clk);
    frame(1'b0, 8'h55, 0, 1'b1); chkTrig(1);
    frame(1'b0, 8'h55, 0, 1'b1); chkTrig(0);
    repeat (40) @(posedge clk);
    frame(1'b0, 8'h55, 0, 1'b1); chkTrig(1);
    wr(8'h0C, 32'h0001_0002);
    wr(8'h10, 32'h55);
    repeat (40) @(posedge clk);
    frame(1'b0, 8'h55, 0, 1'b1); chkTrig(0);
    frame(1'b0, 8'h55, 0, 1'b1); chkTrig(1);
    $display("test packet done");
  endtask

  task automatic t_insuf();
    wr(8'h00, 32'h0000_1801);
    fork
      frame(1'b0, 8'hFF, 0, 1'b1);
      begin
        repeat (40) @(posedge clk);
        wr(8'h00, 32'h0000_1800);
      end
    join
    rd(8'h18); chk("cut word status", 32'h4, d[10:8]);
    rd(8'h14); chk("insufficient flag", 32'h1, d[4]);
    $display("test insufficient done");
  endtask

  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_start();
    t_parity();
    t_stop();
    t_data();
    t_packet();
    t_insuf();
    close_out();
  end
endmodule
